// ===== rtl/leak_monitor.sv
// Leak and break monitor sequencer: excitation, continuity checks, outputs.
// Assumes synchronous sense inputs, one 100 MHz clock, APB register access.
//
// Function
// - Drive 3.75 Hz excitation outside check windows and fault
// - Compare sense level to threshold for leak
// - Leak lights indicator steadily, asserts output
// - First continuity pulse within 2 s
// - Repeat continuity check every 7 s
// - DC pulse and window last 200 ms
// - No excitation or leak judgment in window
// - Returned pulse keeps normal state
// - Missing return declares disconnection fault
// - Fault flashes indicator, asserts output
// - Fault overrides an indicated leak
// - Fault latched, leak evaluation stopped, until reset
// - Polarity low: on at detection; high: off
// - Three range pins select one of four
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module leak_monitor #(
   parameter int LEVEL_W = 12, // Sense level width
   parameter int MS_CYCLES = leak_mon_pkg::MS_TICK_CYCLES, // Cycles per ms
   parameter int AC_HALF = leak_mon_pkg::AC_HALF_CYCLES, // Excitation half period
   parameter int FIRST_MS = leak_mon_pkg::FIRST_CHECK_MS, // First check start
   parameter int PERIOD_MS = leak_mon_pkg::CHECK_PERIOD_MS, // Check interval
   parameter int PULSE_MS = leak_mon_pkg::CHECK_PULSE_MS, // Check length
   parameter int FLASH_MS = leak_mon_pkg::FLASH_HALF_MS // Flash half period
) (
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Power-on reset, active low
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic [LEVEL_W-1:0] sense_level, // Returned band level
   input wire logic loop_return, // DC check pulse seen back
   output logic band_ac_drive, // Leak excitation
   output logic band_dc_drive, // Continuity check pulse
   output logic indicator, // Indicator lamp
   output logic detect_out, // Polarity-selected output
   output logic [1:0] range_sel, // Selected sensing range
   output logic irq // Level interrupt
);
   localparam int CW = 16; // Width of ms counters

   // Elaboration checks: refuse timing the ms counters cannot hold
   if (LEVEL_W < 1 || LEVEL_W > 32) $error("LEVEL_W must be 1..32");
   if (PULSE_MS < 1 || PULSE_MS >= PERIOD_MS) $error("PULSE_MS must be below PERIOD_MS");
   if (PERIOD_MS >= 2**CW || FIRST_MS < 1) $error("Check timing out of range");
   if (FIRST_MS > leak_mon_pkg::FIRST_CHECK_LIMIT_MS) $error("First check too late");
   if (FLASH_MS < 1 || FLASH_MS >= 2**CW) $error("FLASH_MS out of range");

   // ----------------------------------------------------------------
   // Timebases
   // ----------------------------------------------------------------
   logic ms_tick; // One pulse per ms
   logic ac_tick; // One pulse per excitation half period

   tick_divider #(.DIV(MS_CYCLES)) u_ms_div (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tick(ms_tick)
   );

   tick_divider #(.DIV(AC_HALF)) u_ac_div (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tick(ac_tick)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q; // Polarity and range pins
   logic [LEVEL_W-1:0] thresh_q; // Detection threshold
   logic [leak_mon_pkg::EV_W-1:0] ev_stat_q; // Sticky events
   logic [leak_mon_pkg::EV_W-1:0] ev_mask_q; // Event enables
   leak_mon_pkg::seq_state_t state_q; // Sequencer state
   logic [CW-1:0] ms_cnt_q; // ms into startup or into current check period
   logic seen_q; // Return seen in this window
   logic leak_q; // Leak judged present
   logic fault_q; // Disconnection latched
   logic flash_q; // Flash phase
   logic [CW-1:0] flash_cnt_q; // ms into flash phase

   // Bus decode: write at the edge that completes the access
   logic acc_go; // Access phase completes now
   logic wr_go; // Write completes now
   assign acc_go = psel && penable && pready;
   assign wr_go = acc_go && pwrite;

   // Sequencer decode
   logic check_end; // Last cycle of a check window
   logic check_fail; // Window ends without a return
   logic over_thresh; // Level crosses threshold
   logic detected; // Leak or fault to report
   logic [leak_mon_pkg::EV_W-1:0] ev_set; // Events this cycle
   assign check_end = (state_q == leak_mon_pkg::ST_CHECK) && ms_tick
      && (ms_cnt_q == CW'(PULSE_MS - 1));
   assign check_fail = check_end && !(seen_q || loop_return);
   assign over_thresh = sense_level >= thresh_q;
   assign detected = leak_q || fault_q;

   // Range from three pins: highest raised pin wins, none gives zero
   function automatic logic [1:0] range_of(input logic [2:0] pins);
      if (pins[2]) return 2'd3;
      else if (pins[1]) return 2'd2;
      else if (pins[0]) return 2'd1;
      else return 2'd0;
   endfunction : range_of

   // ----------------------------------------------------------------
   // APB slave: one wait state, registered answer
   // ----------------------------------------------------------------
   // Ready rises in the second access cycle so read data can come from a flop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         case (paddr)
            leak_mon_pkg::OFS_CTRL: prdata <= ctrl_q;
            leak_mon_pkg::OFS_THRESH: prdata <= 32'(thresh_q);
            leak_mon_pkg::OFS_STATUS: begin
               // State, leak, fault, range
               prdata <= {24'h0000_00, range_sel, fault_q, leak_q, 2'b00, state_q};
            end
            leak_mon_pkg::OFS_IRQ_STAT: prdata <= 32'(ev_stat_q);
            leak_mon_pkg::OFS_IRQ_MASK: prdata <= 32'(ev_mask_q);
            default: pslverr <= 1'b1; // Unmapped address
         endcase
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Configuration writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= leak_mon_pkg::CTRL_RESET;
         thresh_q <= LEVEL_W'(leak_mon_pkg::THRESH_RESET);
         ev_mask_q <= '0;
      end else if (wr_go) begin
         case (paddr)
            leak_mon_pkg::OFS_CTRL: ctrl_q <= {28'h000_0000, pwdata[3:0]};
            leak_mon_pkg::OFS_THRESH: thresh_q <= pwdata[LEVEL_W-1:0];
            leak_mon_pkg::OFS_IRQ_MASK: ev_mask_q <= pwdata[leak_mon_pkg::EV_W-1:0];
            default: ; // Status read-only, IRQ_STAT cleared below, or unmapped
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      ev_set[leak_mon_pkg::EV_LEAK] = (state_q == leak_mon_pkg::ST_MONITOR)
         && over_thresh && !leak_q;
      ev_set[leak_mon_pkg::EV_FAULT] = check_fail;
      ev_set[leak_mon_pkg::EV_CHECK] = check_end;
   end

   // Write one clears; a new event in the same cycle still sets
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ev_stat_q <= '0;
      end else if (wr_go && paddr == leak_mon_pkg::OFS_IRQ_STAT) begin
         ev_stat_q <= (ev_stat_q & ~pwdata[leak_mon_pkg::EV_W-1:0]) | ev_set;
      end else begin
         ev_stat_q <= ev_stat_q | ev_set;
      end
   end

   // Interrupt level from a flop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) irq <= 1'b0;
      else irq <= |(ev_stat_q & ev_mask_q);
   end

   // ----------------------------------------------------------------
   // Check sequencer
   // ----------------------------------------------------------------
   // Counter runs start to start, so the window sits inside the 7 s period
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= leak_mon_pkg::ST_STARTUP;
         ms_cnt_q <= '0;
      end else begin
         case (state_q)
            leak_mon_pkg::ST_STARTUP: begin
               if (ms_tick && ms_cnt_q == CW'(FIRST_MS - 1)) begin
                  state_q <= leak_mon_pkg::ST_CHECK;
                  ms_cnt_q <= '0;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 1'b1;
               end
            end
            leak_mon_pkg::ST_CHECK: begin
               if (check_fail) begin
                  state_q <= leak_mon_pkg::ST_FAULT;
               end else if (check_end) begin
                  state_q <= leak_mon_pkg::ST_MONITOR;
               end
               if (ms_tick) ms_cnt_q <= ms_cnt_q + 1'b1;
            end
            leak_mon_pkg::ST_MONITOR: begin
               if (ms_tick && ms_cnt_q == CW'(PERIOD_MS - 1)) begin
                  state_q <= leak_mon_pkg::ST_CHECK;
                  ms_cnt_q <= '0;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 1'b1;
               end
            end
            leak_mon_pkg::ST_FAULT: ; // Held until power-on reset
            default: state_q <= leak_mon_pkg::ST_FAULT;
         endcase
      end
   end

   // Return seen during the window; cleared as each window opens
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) seen_q <= 1'b0;
      else if (state_q != leak_mon_pkg::ST_CHECK) seen_q <= 1'b0;
      else if (loop_return) seen_q <= 1'b1;
   end

   // Fault latch and leak judgment
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fault_q <= 1'b0;
         leak_q <= 1'b0;
      end else if (check_fail || fault_q) begin
         fault_q <= 1'b1;
         leak_q <= 1'b0; // Fault replaces the leak
      end else if (state_q == leak_mon_pkg::ST_MONITOR) begin
         leak_q <= over_thresh;
      end
      // Leak held unchanged while a window runs
   end

   // ----------------------------------------------------------------
   // Band drive
   // ----------------------------------------------------------------
   // Excitation stops in window and after fault; DC pulse only in window
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         band_ac_drive <= 1'b0;
         band_dc_drive <= 1'b0;
      end else begin
         band_dc_drive <= (state_q == leak_mon_pkg::ST_CHECK) && !check_end;
         if (state_q == leak_mon_pkg::ST_CHECK || state_q == leak_mon_pkg::ST_FAULT) begin
            band_ac_drive <= 1'b0;
         end else if (ac_tick) begin
            band_ac_drive <= !band_ac_drive;
         end
      end
   end

   // ----------------------------------------------------------------
   // Indicator, output and range
   // ----------------------------------------------------------------
   // Flash at 2 Hz, slow enough to see, never mistaken for steady
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flash_q <= 1'b0;
         flash_cnt_q <= '0;
      end else if (!fault_q) begin
         flash_q <= 1'b1;
         flash_cnt_q <= '0;
      end else if (ms_tick && flash_cnt_q == CW'(FLASH_MS - 1)) begin
         flash_q <= !flash_q;
         flash_cnt_q <= '0;
      end else if (ms_tick) begin
         flash_cnt_q <= flash_cnt_q + 1'b1;
      end
   end

   // Indicator: flashing on fault, steady on leak
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         indicator <= 1'b0;
         detect_out <= 1'b0;
         range_sel <= 2'd0;
      end else begin
         indicator <= fault_q ? flash_q : leak_q;
         detect_out <= detected ^ ctrl_q[leak_mon_pkg::CTRL_POL_BIT];
         range_sel <= range_of(ctrl_q[leak_mon_pkg::CTRL_RANGE_LSB +: 3]);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_ac_quiet_in_check;
      band_dc_drive |-> !band_ac_drive;
   endproperty
   a_ac_quiet_in_check: assert property (p_ac_quiet_in_check)
      else $error("Excitation active during check pulse");

   property p_ac_toggles_on_tick;
      (state_q == leak_mon_pkg::ST_MONITOR && $past(state_q) == leak_mon_pkg::ST_MONITOR
         && ac_tick) |=> (band_ac_drive != $past(band_ac_drive));
   endproperty
   a_ac_toggles_on_tick: assert property (p_ac_toggles_on_tick)
      else $error("Excitation did not toggle");

   property p_leak_tracks;
      (state_q == leak_mon_pkg::ST_MONITOR && !fault_q && !check_fail)
         |=> (leak_q == $past(over_thresh));
   endproperty
   a_leak_tracks: assert property (p_leak_tracks)
      else $error("Leak judgment does not follow threshold");

   property p_steady_led;
      (leak_q && !fault_q) |=> indicator;
   endproperty
   a_steady_led: assert property (p_steady_led)
      else $error("Indicator not lit on leak");

   property p_first_check;
      (state_q == leak_mon_pkg::ST_STARTUP) |-> (ms_cnt_q < CW'(FIRST_MS));
   endproperty
   a_first_check: assert property (p_first_check)
      else $error("First check late");

   property p_period;
      (state_q == leak_mon_pkg::ST_MONITOR) |-> (ms_cnt_q < CW'(PERIOD_MS));
   endproperty
   a_period: assert property (p_period)
      else $error("Check interval exceeded");

   property p_window_holds;
      (state_q == leak_mon_pkg::ST_CHECK && !check_end) |=> (state_q == leak_mon_pkg::ST_CHECK);
   endproperty
   a_window_holds: assert property (p_window_holds)
      else $error("Check window ended early");

   property p_intact;
      (check_end && (seen_q || loop_return)) |=> (!fault_q && state_q == leak_mon_pkg::ST_MONITOR);
   endproperty
   a_intact: assert property (p_intact)
      else $error("Intact loop left normal state");

   property p_miss_faults;
      check_fail |=> fault_q ##1 (band_dc_drive == 1'b0 && band_ac_drive == 1'b0);
   endproperty
   a_miss_faults: assert property (p_miss_faults)
      else $error("Missing return not faulted");

   property p_fault_latched;
      fault_q |=> (fault_q && !leak_q && state_q == leak_mon_pkg::ST_FAULT);
   endproperty
   a_fault_latched: assert property (p_fault_latched)
      else $error("Fault not latched");

   property p_polarity;
      ##1 (detect_out == ($past(detected) ^ $past(ctrl_q[leak_mon_pkg::CTRL_POL_BIT])));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("Output polarity wrong");

   property p_range;
      ##1 (range_sel == range_of($past(ctrl_q[3:1])));
   endproperty
   a_range: assert property (p_range)
      else $error("Range select wrong");
endmodule : leak_monitor

// ===== rtl/leak_mon_pkg.sv
// Constants shared by the leak and break monitor sequencer.
// Assumes a single 100 MHz system clock and an APB register port.
package leak_mon_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 64'd100_000_000; // System clock rate
   localparam longint MS_PER_S = 64'd1000; // Milliseconds per second
   localparam int MS_TICK_CYCLES = int'(CLK_HZ / MS_PER_S); // Cycles per ms tick
   localparam longint EXC_FREQ_CHZ = 64'd375; // Excitation, 3.75 Hz in centihertz
   // Half period of the excitation in cycles, rounded down
   localparam int AC_HALF_CYCLES = int'((CLK_HZ * 64'd100) / (64'd2 * EXC_FREQ_CHZ));
   localparam int FIRST_CHECK_LIMIT_MS = 2000; // First check no later than 2 s
   localparam int FIRST_CHECK_MS = 1000; // Chosen start of first check
   localparam int CHECK_PERIOD_MS = 7000; // Start to start, 7 s
   localparam int CHECK_PULSE_MS = 200; // DC check pulse, 200 ms
   localparam int FLASH_HALF_MS = 250; // Fault flash half period
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00; // Polarity and range select
   localparam logic [7:0] OFS_THRESH = 8'h04; // Detection threshold
   localparam logic [7:0] OFS_STATUS = 8'h08; // Live state
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C; // Sticky events, write one to clear
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // Interrupt enables
   // CTRL fields
   localparam int CTRL_POL_BIT = 0; // Output polarity select
   localparam int CTRL_RANGE_LSB = 1; // Three range pins, bits 3:1
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // Polarity low, range 0
   localparam logic [31:0] THRESH_RESET = 32'h0000_0800; // Mid-scale threshold
   // Event bits of IRQ_STAT and IRQ_MASK
   localparam int EV_LEAK = 0; // Leak judged present
   localparam int EV_FAULT = 1; // Disconnection declared
   localparam int EV_CHECK = 2; // Continuity check finished
   localparam int EV_W = 3; // Number of events
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_STARTUP, ST_MONITOR, ST_CHECK, ST_FAULT} seq_state_t;
endpackage : leak_mon_pkg

// ===== rtl/tick_divider.sv
// One-cycle enable pulse every DIV cycles of the system clock.
// Assumes one clock; used for the ms timebase and excitation toggling.
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 100_000 // Cycles between pulses
) (
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Async reset, active low
   output logic tick // One-cycle pulse
);
   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1; // Counter width
   logic [CW-1:0] cnt_q; // Cycles since last pulse

   // Elaboration check: below two the pulse could never fall again
   if (DIV < 2) begin : g_bad_div
      $error("tick_divider needs DIV of at least 2");
   end

   // Free running count, pulse on wrap
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (cnt_q == CW'(DIV - 1)) begin
         cnt_q <= '0;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : tick_divider

// ===== bench/band_loop_model.sv
// Sensing band loop: terminator return path and leaked-liquid level.
// Assumes the monitor drives its check pulse as a level.
`timescale 1ns/1ps
module band_loop_model #(
   parameter int LEVEL_W = 12 // Sense level width
) (
   input wire logic band_dc_drive, // Check pulse from monitor
   input wire logic intact, // Terminator still reached
   input wire logic [LEVEL_W-1:0] wet_level, // Level through liquid
   output logic loop_return, // Pulse seen back
   output logic [LEVEL_W-1:0] sense_level // Level at sense pin
);
   // ----------------------------------------------------------------
   // Return paths
   // ----------------------------------------------------------------
   // Band spans the one terminal pair, so only a driven pulse returns
   assign loop_return = band_dc_drive & intact;
   // Rectified liquid level; a dry band returns nothing
   assign sense_level = wet_level;
endmodule : band_loop_model

// ===== bench/leak_and_break_monitor_sequencer_tb_top.sv
// Self-checking bench for the leak and break monitor sequencer.
// Assumes shortened ms tick and periods; APB master and band model here.
`timescale 1ns/1ps
module leak_and_break_monitor_sequencer_tb_top;
   // ----------------------------------------------------------------
   // Shortened timing, keeps the run under a thousand cycles
   // ----------------------------------------------------------------
   localparam int MS = 10; // Cycles per ms tick
   localparam int ACH = 7; // Excitation half period
   localparam int FIRST = 5; // First check, ms
   localparam int PER = 20; // Check period, ms
   localparam int PUL = 4; // Check pulse, ms
   localparam int FL = 2; // Flash half period, ms
   logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0; // Drives
   logic [7:0] paddr = 0; // APB address
   logic [31:0] pwdata = 0, prdata, lfsr_q; // Data and random state
   logic pready, pslverr, loop_return, band_ac_drive, band_dc_drive; // Outputs
   logic indicator, detect_out, irq, intact = 1, meas_done = 0; // Status
   logic [1:0] range_sel; // Range seen
   logic [11:0] sense_level, wet_level = 0, thr; // Levels
   logic [32:0] exp_q[$]; // Expected read results
   int err_total = 0, checks_done = 0, n, i; // Counters
   leak_monitor #(.MS_CYCLES(MS), .AC_HALF(ACH), .FIRST_MS(FIRST), .PERIOD_MS(PER),
      .PULSE_MS(PUL), .FLASH_MS(FL)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_level(sense_level),
      .loop_return(loop_return), .band_ac_drive(band_ac_drive),
      .band_dc_drive(band_dc_drive), .indicator(indicator), .detect_out(detect_out),
      .range_sel(range_sel), .irq(irq));
   band_loop_model band (.band_dc_drive(band_dc_drive), .intact(intact),
      .wet_level(wet_level), .loop_return(loop_return), .sense_level(sense_level));
   // ----------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ----------------------------------------------------------------
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Whole run needs under 2000 cycles
   initial begin
      #50000;
      err_total++;
      end_sim();
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer; reads leave their expectation in the queue
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [32:0] e);
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge sys_clk);
      penable <= 1;
      // Hold the request until the edge that samples pready high
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wait_cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : wait_cyc
   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // Read results are taken at the edge that samples pready high
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         check({pslverr, prdata}, exp_q.pop_front());
   end
   // ----------------------------------------------------------------
   // Check-pulse timing, watched from the first release of reset
   // ----------------------------------------------------------------
   initial begin : timing_watch
      int k;
      logic p;
      @(posedge resetn);
      k = 0;
      while (band_dc_drive !== 1'b1) begin @(negedge sys_clk); k++; end
      check(33'(k <= FIRST * MS + 4), 33'd1);
      check(33'(band_ac_drive), 33'd0);
      k = 0;
      while (band_dc_drive === 1'b1) begin @(negedge sys_clk); k++; end
      check(33'(k >= PUL * MS - 2 && k <= PUL * MS), 33'd1);
      p = band_ac_drive;
      while (band_ac_drive === p) begin @(negedge sys_clk); k++; end
      p = band_ac_drive;
      n = 0;
      while (band_ac_drive === p) begin @(negedge sys_clk); k++; n++; end
      check(33'(n), 33'(ACH));
      while (band_dc_drive !== 1'b1) begin @(negedge sys_clk); k++; end
      check(33'(k), 33'(PER * MS));
      meas_done = 1;
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin : main_seq
      lfsr_q = 32'h6245_566c;
      repeat (20) @(posedge sys_clk);
      resetn <= 1;
      apb(leak_mon_pkg::OFS_CTRL, 0, 0, {1'b0, leak_mon_pkg::CTRL_RESET});
      apb(leak_mon_pkg::OFS_THRESH, 0, 0, {1'b0, leak_mon_pkg::THRESH_RESET});
      apb(leak_mon_pkg::OFS_IRQ_MASK, 0, 0, 33'h0_0000_0000);
      apb(8'h14, 0, 0, 33'h1_0000_0000);
      for (i = 0; i < 8; i++) begin
         apb(leak_mon_pkg::OFS_CTRL, 1, 32'(i << 1), 0);
         wait_cyc(2);
         check(33'(range_sel), i[2] ? 33'd3 : i[1] ? 33'd2 : 33'(i[0]));
      end
      lfsr_q = lfsr_next(lfsr_q);
      thr = lfsr_q[11:0] | 12'h001;
      apb(leak_mon_pkg::OFS_CTRL, 1, 0, 0);
      apb(leak_mon_pkg::OFS_THRESH, 1, {20'h0_0000, thr}, 0);
      apb(leak_mon_pkg::OFS_THRESH, 0, 0, {21'h0_0000, thr});
      wait (meas_done);
      check(33'(indicator), 33'd0);
      @(posedge sys_clk);
      wet_level <= thr - 12'h001;
      wait_cyc(60);
      check({31'h0, indicator, detect_out}, 33'd0);
      @(posedge sys_clk);
      wet_level <= thr;
      n = 0;
      while (indicator !== 1'b1 && n < 60) begin @(negedge sys_clk); n++; end
      wait_cyc(2);
      check({31'h0, indicator, detect_out}, 33'd3);
      apb(leak_mon_pkg::OFS_CTRL, 1, 32'h0000_0001, 0);
      wait_cyc(3);
      check(33'(detect_out), 33'd0);
      // Raise, mask, unmask, then clear the leak event
      for (i = 0; i < 4; i++) begin
         apb(i < 3 ? leak_mon_pkg::OFS_IRQ_MASK : leak_mon_pkg::OFS_IRQ_STAT, 1,
            i == 1 ? 32'h0 : i == 2 ? 32'h3 : 32'h1, 0);
         wait_cyc(3);
         check(33'(irq), 33'(i == 0 || i == 2));
      end
      // Break the loop while the leak is shown
      @(posedge sys_clk);
      intact <= 0;
      while (band_dc_drive !== 1'b1) @(negedge sys_clk);
      while (band_dc_drive === 1'b1) @(negedge sys_clk);
      wait_cyc(3);
      check({31'h0, irq, detect_out}, 33'd2);
      while (indicator === 1'b1) @(negedge sys_clk);
      n = 0;
      while (indicator !== 1'b1) begin @(negedge sys_clk); n++; end
      check(33'(n), 33'(FL * MS));
      // Status: fault state, fault set, leak cleared, range zero
      apb(leak_mon_pkg::OFS_STATUS, 0, 0, 33'h0_0000_0023);
      @(posedge sys_clk);
      intact <= 1;
      wet_level <= 0;
      n = 0;
      repeat (PER * MS + 20) begin @(negedge sys_clk); n += int'(band_dc_drive); end
      check({n[31:0], irq}, 33'd1);
      @(posedge sys_clk);
      resetn <= 0;
      wait_cyc(3);
      @(posedge sys_clk);
      resetn <= 1;
      wait_cyc(3);
      check({31'h0, indicator, detect_out}, 33'd0);
      end_sim();
   end
endmodule : leak_and_break_monitor_sequencer_tb_top
